/* pkg/host_wakeup_chirp_detect_params.svh */
// Offsets, field positions, reset values and timing counts of the line-event detectors
`ifndef HOST_WAKEUP_CHIRP_DETECT_PARAMS_SVH
`define HOST_WAKEUP_CHIRP_DETECT_PARAMS_SVH

// Clock rate
`define HWCD_CLK_MHZ         40

// K filter: more than 2.5 us, so one cycle beyond the exact figure
`define HWCD_KFILT_NS        2500
`define HWCD_KFILT_CYC       ((`HWCD_KFILT_NS * `HWCD_CLK_MHZ) / 1000 + 1)

// Chirp must end no later than 7.0 ms after reset began (longest, rounds down)
`define HWCD_CHIRP_END_US    7000
`define HWCD_CHIRP_END_CYC   (`HWCD_CHIRP_END_US * `HWCD_CLK_MHZ)

// A valid chirp lasts at least 1.0 ms (least, rounds up)
`define HWCD_CHIRP_MIN_US    1000
`define HWCD_CHIRP_MIN_CYC   ((`HWCD_CHIRP_MIN_US * `HWCD_CLK_MHZ * 1000 + 999) / 1000)

// Resume K must start before 1 ms from wake K onset (longest, rounds down)
`define HWCD_RESUME_LIMIT_US  1000
`define HWCD_RESUME_LIMIT_CYC (`HWCD_RESUME_LIMIT_US * `HWCD_CLK_MHZ)

// Register byte offsets
`define HWCD_OFS_CTRL        12'h000
`define HWCD_OFS_STATE       12'h004
`define HWCD_OFS_STATUS      12'h008
`define HWCD_OFS_MASK        12'h00C
`define HWCD_OFS_LINE        12'h010

// Control register fields
`define HWCD_CTRL_REQ_LSB    0
`define HWCD_CTRL_REQ_MSB    2
`define HWCD_CTRL_ALLOW_BIT  8

// Event status and mask bit positions
`define HWCD_EV_WAKE         0
`define HWCD_EV_GOOD         1
`define HWCD_EV_FAIL         2

// Reset values
`define HWCD_ALLOW_RST       1'b0
`define HWCD_MASK_RST        3'h0
`define HWCD_STATUS_RST      3'h0

// State-change request codes
`define HWCD_CMD_NONE        3'h0
`define HWCD_CMD_IDLE        3'h1
`define HWCD_CMD_SUSPEND     3'h2
`define HWCD_CMD_RESET       3'h3
`define HWCD_CMD_RESUME      3'h4
`define HWCD_CMD_OPER        3'h5

// Line condition codes at full speed
`define HWCD_LINE_SE0        2'h0
`define HWCD_LINE_J          2'h1
`define HWCD_LINE_K          2'h2

`endif

/* pkg/hwcd_pkg.sv */
// Types shared by the line-event detector design
package hwcd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE        = 3'b000,
      ST_SUSPEND     = 3'b001,
      ST_RESET       = 3'b010,
      ST_RESUME      = 3'b011,
      ST_OPERATIONAL = 3'b100
   } host_state_t;

   typedef enum logic [1:0] {
      CH_OFF  = 2'b00,
      CH_WAIT = 2'b01,
      CH_IN_K = 2'b10
   } chirp_state_t;

endpackage

/* hw/line_hold_filter.sv */
// Counts how long a line level has held and flags when it passes a threshold
`timescale 1ns/1ps

module line_hold_filter #(
   parameter int          CW     = 8,
   parameter logic [CW-1:0] THRESH = 8'h65
) (
   input  wire logic          clock,
   input  wire logic          sys_rst,
   input  wire logic          enable,
   input  wire logic          level,
   output logic               held,
   output logic [CW-1:0]      holdCount
);

   // Saturates so a long level never wraps into a false restart
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         holdCount <= '0;
      end else if (!enable || !level) begin
         holdCount <= '0;
      end else if (holdCount != THRESH) begin
         holdCount <= holdCount + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         held <= 1'b0;
      end else begin
         held <= enable && level && (holdCount >= THRESH - 1'b1);
      end
   end

endmodule

/* hw/host_wakeup_chirp_detect.sv */
// Host-port remote-wakeup and device-chirp detectors with APB registers
`timescale 1ns/1ps
`include "host_wakeup_chirp_detect_params.svh"

// Notes on behaviour
// - Wake detection runs the same sequence and timing for full- and low-speed devices.
// - A wake K counts only after it has held more than 2.5 us, then sets the wake flag.
// - Resume K starts on the resume command, and never later than 1 ms after K onset.
// - The chirp detector runs only in the bus-reset state and is armed by that command.
// - A chirp is recognised only after K has held more than 2.5 us.
// - A recognised chirp of at least 1.0 ms ending by 7.0 ms after reset sets chirp-good.
// - A recognised chirp still running at 7 ms after reset sets chirp-fail.
// - The chirp detector turns itself off as it raises chirp-good or chirp-fail.
// - Wake detection runs only in suspend and only with wake detection allowed.
// - A detected wake is reported in the wake bit of the event status register.
module host_wakeup_chirp_detect #(
   parameter int        TW               = 20,
   parameter int        FW               = 8,
   parameter logic [TW-1:0] CHIRP_END_CYC    = TW'(`HWCD_CHIRP_END_CYC),
   parameter logic [TW-1:0] CHIRP_MIN_CYC    = TW'(`HWCD_CHIRP_MIN_CYC),
   parameter logic [TW-1:0] RESUME_LIMIT_CYC = TW'(`HWCD_RESUME_LIMIT_CYC)
) (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  bus_line_condition,
   input  wire logic        lowSpeedPort,
   output logic             resumeDrive,
   output logic             busResetDrive,
   output logic             irq
);

   localparam logic [FW-1:0] KFILT_CYC = FW'(`HWCD_KFILT_CYC);
   // Two cycles of margin so the resume K is on the bus before the limit
   localparam logic [TW-1:0] AUTO_RESUME_CYC = RESUME_LIMIT_CYC - TW'(2);

   hwcd_pkg::host_state_t  hostMode_r;
   hwcd_pkg::chirp_state_t chirpState_r;

   logic          allow_r;
   logic [2:0]    status_r;
   logic [2:0]    status_nxt;
   logic [2:0]    mask_r;
   logic [2:0]    readSnap_r;
   logic [TW-1:0] wakeAge_r;
   logic          wakePending_r;
   logic [TW-1:0] resetAge_r;
   logic [TW-1:0] chirpLen_r;
   logic          wakeHeld;
   logic          wakeHeldDly_r;
   logic          chirpHeld;
   logic          lineK;
   logic          inReset;
   logic          setupPhase;
   logic          accessPhase;
   logic          mapped;
   logic          ctrlWrite;
   logic [2:0]    request;
   logic          autoResume;
   logic          wakeEvent;
   logic          chirpGood;
   logic          chirpFail;
   logic          wakeActive;
   logic          chirpWaiting;

   // Low-speed J and K are swapped on the wires; decode hides the speed
   function automatic logic isK(input logic [1:0] line, input logic ls);
      isK = ls ? (line == `HWCD_LINE_J) : (line == `HWCD_LINE_K);
   endfunction

   function automatic logic isMapped(input logic [11:0] addr);
      isMapped = (addr == `HWCD_OFS_CTRL) || (addr == `HWCD_OFS_STATE) ||
                 (addr == `HWCD_OFS_STATUS) || (addr == `HWCD_OFS_MASK) ||
                 (addr == `HWCD_OFS_LINE);
   endfunction

   assign lineK = isK(bus_line_condition, lowSpeedPort);

   // ---------------- APB slave ----------------
   assign setupPhase  = psel && !penable;
   assign accessPhase = psel && penable;
   assign mapped      = isMapped(paddr);
   // Zero wait states: every register answers in its access cycle
   assign pready      = 1'b1;
   assign pslverr     = accessPhase && !mapped;
   assign ctrlWrite   = accessPhase && pwrite && (paddr == `HWCD_OFS_CTRL);
   assign request     = ctrlWrite ? pwdata[`HWCD_CTRL_REQ_MSB:`HWCD_CTRL_REQ_LSB]
                                  : `HWCD_CMD_NONE;

   // Read data is captured in the setup cycle so it is stable in the access cycle
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0;
      end else if (setupPhase && !pwrite) begin
         case (paddr)
            `HWCD_OFS_CTRL:   prdata <= {23'h0, allow_r, 8'h0};
            `HWCD_OFS_STATE:  prdata <= {29'h0, hostMode_r};
            `HWCD_OFS_STATUS: prdata <= {29'h0, status_r};
            `HWCD_OFS_MASK:   prdata <= {29'h0, mask_r};
            `HWCD_OFS_LINE:   prdata <= {30'h0, bus_line_condition};
            default:          prdata <= 32'h0;
         endcase
      end
   end

   // Only the bits that software actually saw are cleared by the read
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         readSnap_r <= 3'h0;
      end else if (setupPhase) begin
         readSnap_r <= (!pwrite && paddr == `HWCD_OFS_STATUS) ? status_r : 3'h0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         allow_r <= `HWCD_ALLOW_RST;
      end else if (ctrlWrite) begin
         allow_r <= pwdata[`HWCD_CTRL_ALLOW_BIT];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mask_r <= `HWCD_MASK_RST;
      end else if (accessPhase && pwrite && paddr == `HWCD_OFS_MASK) begin
         mask_r <= pwdata[2:0];
      end
   end

   // ---------------- Event status ----------------
   always_comb begin
      status_nxt = status_r;
      if (accessPhase && !pwrite && paddr == `HWCD_OFS_STATUS) begin
         status_nxt = status_nxt & ~readSnap_r;
      end
      // Set wins over a clear in the same cycle
      if (wakeEvent) begin
         status_nxt[`HWCD_EV_WAKE] = 1'b1;
      end
      if (chirpGood) begin
         status_nxt[`HWCD_EV_GOOD] = 1'b1;
      end
      if (chirpFail) begin
         status_nxt[`HWCD_EV_FAIL] = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         status_r <= `HWCD_STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   assign irq = |(status_r & mask_r);

   // ---------------- Host state ----------------
   // Requests that are illegal from the current state are ignored
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         hostMode_r <= hwcd_pkg::ST_IDLE;
      end else begin
         case (request)
            `HWCD_CMD_IDLE: begin
               hostMode_r <= hwcd_pkg::ST_IDLE;
            end
            `HWCD_CMD_SUSPEND: begin
               if (hostMode_r == hwcd_pkg::ST_OPERATIONAL) begin
                  hostMode_r <= hwcd_pkg::ST_SUSPEND;
               end
            end
            `HWCD_CMD_RESET: begin
               hostMode_r <= hwcd_pkg::ST_RESET;
            end
            `HWCD_CMD_RESUME: begin
               if (hostMode_r == hwcd_pkg::ST_SUSPEND) begin
                  hostMode_r <= hwcd_pkg::ST_RESUME;
               end
            end
            `HWCD_CMD_OPER: begin
               if (hostMode_r == hwcd_pkg::ST_RESET || hostMode_r == hwcd_pkg::ST_RESUME) begin
                  hostMode_r <= hwcd_pkg::ST_OPERATIONAL;
               end
            end
            default: begin
               // Firmware late: hardware starts resume itself to meet the limit
               if (autoResume) begin
                  hostMode_r <= hwcd_pkg::ST_RESUME;
               end
            end
         endcase
      end
   end

   // Flags and drives follow the state, never the request being decoded
   assign inReset = (hostMode_r == hwcd_pkg::ST_RESET);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         resumeDrive   <= 1'b0;
         busResetDrive <= 1'b0;
      end else begin
         resumeDrive   <= (hostMode_r == hwcd_pkg::ST_RESUME);
         busResetDrive <= inReset;
      end
   end

   // ---------------- Remote wakeup ----------------
   assign wakeActive = (hostMode_r == hwcd_pkg::ST_SUSPEND) && allow_r;

   line_hold_filter #(
      .CW     (FW),
      .THRESH (KFILT_CYC)
   ) wakeFilter (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .enable    (wakeActive),
      .level     (lineK),
      .held      (wakeHeld),
      .holdCount ()
   );

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wakeHeldDly_r <= 1'b0;
      end else begin
         wakeHeldDly_r <= wakeHeld;
      end
   end

   assign wakeEvent = wakeHeld && !wakeHeldDly_r && wakeActive;

   // Age from K onset; the filter time is already behind us at recognition
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wakePending_r <= 1'b0;
         wakeAge_r     <= '0;
      end else if (hostMode_r != hwcd_pkg::ST_SUSPEND) begin
         wakePending_r <= 1'b0;
         wakeAge_r     <= '0;
      end else if (wakeEvent) begin
         wakePending_r <= 1'b1;
         wakeAge_r     <= TW'(KFILT_CYC) + TW'(1);
      end else if (wakePending_r && wakeAge_r != AUTO_RESUME_CYC) begin
         wakeAge_r <= wakeAge_r + TW'(1);
      end
   end

   // Limitation: a late firmware resume is covered, but no flag reports it
   assign autoResume = wakePending_r && (wakeAge_r == AUTO_RESUME_CYC);

   // ---------------- Device chirp ----------------
   assign chirpWaiting = (chirpState_r == hwcd_pkg::CH_WAIT);

   line_hold_filter #(
      .CW     (FW),
      .THRESH (KFILT_CYC)
   ) chirpFilter (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .enable    (chirpWaiting),
      .level     (lineK),
      .held      (chirpHeld),
      .holdCount ()
   );

   // Time since the bus-reset request
   // Saturates at the end time, so a stuck K is flagged only once
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         resetAge_r <= '0;
      end else if (request == `HWCD_CMD_RESET) begin
         resetAge_r <= '0;
      end else if (inReset && resetAge_r != CHIRP_END_CYC) begin
         resetAge_r <= resetAge_r + TW'(1);
      end
   end

   // Gated by the state too: the chirp state lags a reset exit by one cycle
   assign chirpGood = inReset && (chirpState_r == hwcd_pkg::CH_IN_K) && !lineK &&
                      (chirpLen_r >= CHIRP_MIN_CYC) && (resetAge_r < CHIRP_END_CYC);
   assign chirpFail = inReset && (chirpState_r == hwcd_pkg::CH_IN_K) &&
                      (resetAge_r == CHIRP_END_CYC);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         chirpState_r <= hwcd_pkg::CH_OFF;
      end else if (request == `HWCD_CMD_RESET) begin
         chirpState_r <= hwcd_pkg::CH_WAIT;
      end else if (!inReset) begin
         chirpState_r <= hwcd_pkg::CH_OFF;
      end else begin
         case (chirpState_r)
            hwcd_pkg::CH_WAIT: begin
               if (chirpHeld) begin
                  chirpState_r <= hwcd_pkg::CH_IN_K;
               end else if (resetAge_r == CHIRP_END_CYC) begin
                  // No chirp at all: a full-speed device, nothing to flag
                  chirpState_r <= hwcd_pkg::CH_OFF;
               end
            end
            hwcd_pkg::CH_IN_K: begin
               if (chirpGood || chirpFail) begin
                  chirpState_r <= hwcd_pkg::CH_OFF;
               end else if (!lineK) begin
                  // Too short to be a chirp: keep watching
                  chirpState_r <= hwcd_pkg::CH_WAIT;
               end
            end
            default: begin
               chirpState_r <= hwcd_pkg::CH_OFF;
            end
         endcase
      end
   end

   // Chirp length counted from K onset
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         chirpLen_r <= '0;
      end else if (chirpWaiting) begin
         chirpLen_r <= TW'(KFILT_CYC) + TW'(1);
      end else if (chirpState_r == hwcd_pkg::CH_IN_K && chirpLen_r != CHIRP_END_CYC) begin
         chirpLen_r <= chirpLen_r + TW'(1);
      end
   end

endmodule

/* bench/hwcd_props.sv */
// Port-level assertions for the line-event detectors
`timescale 1ns/1ps
module hwcd_props (
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [1:0]  bus_line_condition,
   input wire logic        lowSpeedPort,
   input wire logic        resumeDrive,
   input wire logic        busResetDrive,
   input wire logic        irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic        acc;
   logic        isK;
   logic [15:0] runLen;
   logic [15:0] endLen;
   assign acc = psel && penable;
   assign isK = bus_line_condition == (lowSpeedPort ? 2'h1 : 2'h2);
   // Saturating run counters, so a long stuck K never wraps to a short one
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         runLen <= 16'h0;
         endLen <= 16'h0;
      end else begin
         runLen <= isK ? (runLen == 16'hFFFF ? runLen : runLen + 16'h1) : 16'h0;
         endLen <= isK ? endLen : (runLen == 16'h0 ? endLen : runLen);
      end
   end
   chk_unmapped_err: assert property (acc && !pwrite && paddr > 12'h010 |->
      pslverr && prdata == 32'h0) else $error("unmapped read not refused");
   chk_err_access: assert property (pslverr |-> acc)
      else $error("pslverr outside access");
   chk_drive_excl: assert property (!(resumeDrive && busResetDrive))
      else $error("reset and resume driven together");
   chk_reset_cmd: assert property (acc && pwrite && paddr == 12'h000 &&
      pwdata[2:0] == 3'h3 |-> ##2 busResetDrive) else $error("reset request not obeyed");
   chk_reset_hold: assert property ($fell(busResetDrive) |->
      $past(acc && pwrite && paddr == 12'h000, 2)) else $error("left reset without request");
   chk_flag_after_k: assert property ($rose(irq) && !$past(acc) |->
      runLen > 16'h0064 || endLen > 16'h0064) else $error("flag without held K");
   chk_irq_hold: assert property ($fell(irq) |->
      $past(acc && (paddr == 12'h008 || paddr == 12'h00C))) else $error("flag lost by itself");
   chk_ctrl_read0: assert property (psel && !penable && !pwrite && paddr == 12'h000 |=>
      prdata[2:0] == 3'h0) else $error("request field not write-only");
endmodule
bind host_wakeup_chirp_detect hwcd_props i_props (.clock(clock), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pslverr(pslverr), .bus_line_condition(bus_line_condition),
   .lowSpeedPort(lowSpeedPort), .resumeDrive(resumeDrive), .busResetDrive(busResetDrive),
   .irq(irq));

/* bench/usb_line_model.sv */
// Behavioural downstream device: the line state it puts on the host port
`timescale 1ns/1ps
module usb_line_model (
   input  wire logic       lowSpeed,
   input  wire logic [1:0] drive,
   output logic [1:0]      lineCode
);
   // Released bus settles to J through the device pull-up
   always_comb begin
      case (drive)
         2'h1: lineCode = lowSpeed ? 2'h1 : 2'h2;
         2'h2: lineCode = 2'h0;
         default: lineCode = lowSpeed ? 2'h2 : 2'h1;
      endcase
   end
endmodule

/* bench/tb_host_wakeup_chirp_detect.sv */
// Register-level testbench for the line-event detectors
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_host_wakeup_chirp_detect;
   localparam int         RLIM = 600;
   localparam logic [1:0] LJ   = 2'h0;
   localparam logic [1:0] LK   = 2'h1;
   localparam logic [1:0] LSE0 = 2'h2;
   logic        clock   = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        lowSpd  = 1'b0;
   logic [1:0]  lineDrv = 2'h0;
   logic [31:0] prdata;
   logic [31:0] q;
   logic [1:0]  lineCode;
   logic        pready, pslverr, resumeDrive, busResetDrive, irq, e;
   int          nMismatch = 0;
   int          numChecks = 0;
   int          n;

   always #12.5 clock = ~clock;

   usb_line_model i_dev (.lowSpeed(lowSpd), .drive(lineDrv), .lineCode(lineCode));
   host_wakeup_chirp_detect #(.CHIRP_END_CYC(20'hBB8), .CHIRP_MIN_CYC(20'h1F4),
      .RESUME_LIMIT_CYC(20'h258)) i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_line_condition(lineCode),
      .lowSpeedPort(lowSpd), .resumeDrive(resumeDrive), .busResetDrive(busResetDrive),
      .irq(irq));

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
      int k;
      k = 0;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clock);
      end
      if (pready !== 1'b1) begin
         nMismatch++;
      end
      r = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        er;
      xfer(1'b1, a, d, r, er);
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] x, input string nm);
      logic [31:0] r;
      logic        er;
      xfer(1'b0, a, 32'h0, r, er);
      `CHK(nm, x, r)
   endtask
   task automatic drv(input logic [1:0] v, input int c);
      lineDrv <= v;
      repeat (c) @(posedge clock);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      rdChk(12'h000, 32'h0, "ctrl");
      rdChk(12'h004, 32'h0, "state");
      rdChk(12'h008, 32'h0, "status");
      rdChk(12'h00C, 32'h0, "mask");
      rdChk(12'h010, 32'h1, "line");
      xfer(1'b0, 12'h020, 32'h0, q, e);
      `CHK("slverr", 1'b1, e)
      wr(12'h00C, 32'h7);
      rdChk(12'h00C, 32'h7, "mask");
      $display("test registers done");
      wr(12'h000, 32'h3);
      wr(12'h000, 32'h5);
      wr(12'h000, 32'h2);
      rdChk(12'h004, 32'h1, "state");
      drv(LK, 150);
      drv(LJ, 5);
      rdChk(12'h008, 32'h0, "status");
      wr(12'h000, 32'h100);
      drv(LK, 95);
      drv(LJ, 5);
      rdChk(12'h008, 32'h0, "status");
      drv(LK, 110);
      `CHK("irq", 1'b1, irq)
      rdChk(12'h008, 32'h1, "status");
      rdChk(12'h008, 32'h0, "status");
      `CHK("irq", 1'b0, irq)
      wr(12'h000, 32'h104);
      drv(LJ, 2);
      `CHK("resume", 1'b1, resumeDrive)
      rdChk(12'h004, 32'h3, "state");
      $display("test wake full speed done");
      wr(12'h000, 32'h105);
      wr(12'h000, 32'h102);
      lowSpd <= 1'b1;
      lineDrv <= LK;
      n = 0;
      // Sample off the edge: n is the count of edges since the K began
      @(negedge clock);
      while (resumeDrive !== 1'b1 && n < 700) begin
         n++;
         @(negedge clock);
      end
      `CHK("resume in time", 1'b1, n <= RLIM)
      rdChk(12'h008, 32'h1, "status");
      lowSpd <= 1'b0;
      drv(LJ, 2);
      $display("test wake low speed done");
      wr(12'h00C, 32'h0);
      wr(12'h000, 32'h3);
      drv(LSE0, 10);
      `CHK("reset drive", 1'b1, busResetDrive)
      drv(LK, 600);
      drv(LSE0, 3);
      `CHK("irq", 1'b0, irq)
      wr(12'h00C, 32'h2);
      drv(LSE0, 1);
      `CHK("irq", 1'b1, irq)
      rdChk(12'h008, 32'h2, "status");
      drv(LK, 600);
      drv(LSE0, 3);
      rdChk(12'h008, 32'h0, "status");
      rdChk(12'h004, 32'h2, "state");
      $display("test chirp good done");
      wr(12'h000, 32'h3);
      drv(LSE0, 10);
      drv(LK, 300);
      drv(LSE0, 20);
      rdChk(12'h008, 32'h0, "status");
      drv(LK, 3000);
      rdChk(12'h008, 32'h4, "status");
      drv(LSE0, 5);
      rdChk(12'h008, 32'h0, "status");
      wr(12'h000, 32'h5);
      drv(LK, 600);
      drv(LSE0, 3);
      rdChk(12'h008, 32'h0, "status");
      wr(12'h000, 32'h1);
      rdChk(12'h004, 32'h0, "state");
      $display("test chirp fail done");
      close_out;
   end

   initial begin
      repeat (30000) @(posedge clock);
      nMismatch++;
      close_out;
   end
endmodule
